// ---- hdl/tofrp_pkg.sv ----
package tofrp_pkg;

  // command codes on the management command port
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_TON_LIMIT    = 8'h62;
  localparam logic [7:0] CMD_TON_POLICY   = 8'h63;
  localparam logic [7:0] CMD_TIME_UNIT    = 8'hD2;

  // policy field positions
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  // response selections
  localparam logic [1:0] RESP_IGNORE   = 2'h0;
  localparam logic [1:0] RESP_RUN_WAIT = 2'h1;
  localparam logic [1:0] RESP_DISABLE  = 2'h2;
  localparam logic [1:0] RESP_LATCH    = 2'h3;

  // retry codes
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // reset values
  localparam logic [7:0]  POLICY_RST    = 8'hC0;
  localparam logic [15:0] LIMIT_RST     = 16'h0032;
  localparam logic [7:0]  TIME_UNIT_RST = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } tofrp_cmd_t;

endpackage

// ---- hdl/tofrp_ticker.sv ----
`timescale 1ns/10ps
`default_nettype none
module tofrp_ticker #(
  parameter int W = 17
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // control
  input  wire logic [W-1:0] period_i,
  input  wire logic         restart_i,
  // tick out
  output logic              tick_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire          wrap = (cnt_reg == period_i - W'(1));

  assign cnt_next = (restart_i || wrap) ? '0 : cnt_reg + W'(1);
  assign tick_o   = wrap && !restart_i;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule // tofrp_ticker
`default_nettype wire

// ---- hdl/tofrp_policy.sv ----
`timescale 1ns/10ps
`default_nettype none
module tofrp_policy #(
  parameter int MS_CYC = tofrp_pkg::MS_CYC
) (
  // clock and reset (reset also stands for bias loss)
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // management command port
  input  wire tofrp_pkg::tofrp_cmd_t cmd_i,
  output logic [15:0]                rd_data_o,
  // converter side
  input  wire logic                  on_cmd_i,
  input  wire logic                  vout_ok_i,
  input  wire logic                  other_fault_i,
  input  wire logic                  fault_bit_clr_i,
  output logic                       out_en_o,
  output logic                       fault_o,
  output logic [2:0]                 attempts_o
);

  typedef enum logic [2:0] {
    ST_OFF, ST_START, ST_RUN, ST_HOLD, ST_WAIT, ST_LATCH
  } tofrp_state_t;

  tofrp_state_t state_reg;
  tofrp_state_t state_next;
  logic [7:0]   policy_reg;
  logic [15:0]  limit_reg;
  logic [7:0]   unit_reg;
  logic [15:0]  ms_cnt_reg;
  logic [2:0]   attempts_reg;
  logic [2:0]   attempts_next;
  logic         flag_reg;
  logic         on_d_reg;
  logic         out_en_reg;
  logic [15:0]  rd_data_reg;
  logic         ms_tick;

  // register decode
  wire wr_limit  = cmd_i.wr && (cmd_i.code == tofrp_pkg::CMD_TON_LIMIT);
  wire wr_policy = cmd_i.wr && (cmd_i.code == tofrp_pkg::CMD_TON_POLICY);
  wire wr_unit   = cmd_i.wr && (cmd_i.code == tofrp_pkg::CMD_TIME_UNIT);
  wire clr_all   = cmd_i.wr && (cmd_i.code == tofrp_pkg::CMD_CLEAR_FAULTS);

  wire [1:0] resp  = policy_reg[tofrp_pkg::RESP_MSB:tofrp_pkg::RESP_LSB];
  wire [2:0] retry = policy_reg[tofrp_pkg::RETRY_MSB:tofrp_pkg::RETRY_LSB];
  wire [2:0] dfld  = policy_reg[tofrp_pkg::DELAY_MSB:tofrp_pkg::DELAY_LSB];

  // unit scale and count decode
  // unit from 0xD2
  // vout fault unit shared; one unit is (unit_reg + 1) ms
  wire [16:0] unit_ms  = 17'(unit_reg) + 17'd1;
  wire [15:0] delay_ms = 16'(unit_ms << dfld);
  wire        delay_done = (ms_cnt_reg >= delay_ms);

  // turn-on timeout, zero limit disables it
  wire fault_det = (state_reg == ST_START) && !vout_ok_i &&
                   (limit_reg != 16'h0000) && (ms_cnt_reg >= limit_reg);

  // no retry code latches off; bounded count; unlimited
  wire may_retry = (retry == tofrp_pkg::RETRY_FOREVER) ||
                   ((retry != tofrp_pkg::RETRY_NONE) && (attempts_reg < retry));
  wire tofrp_state_t retry_state = may_retry ? ST_WAIT : ST_LATCH;

  wire on_fall  = on_d_reg && !on_cmd_i;
  // any clear path; a new detection wins over the clear
  wire flag_clr = clr_all || fault_bit_clr_i || on_fall;
  wire flag_set = fault_det && (resp != tofrp_pkg::RESP_IGNORE);
  wire flag_next = flag_set || (flag_reg && !flag_clr);

  wire restart_tick = (state_next != state_reg);

  tofrp_ticker #(
    .W (17)
  ) u_ms_tick (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .period_i  (17'(MS_CYC)),
    .restart_i (restart_tick),
    .tick_o    (ms_tick)
  );

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF:   if (on_cmd_i) state_next = ST_START;
      ST_START:
        if (vout_ok_i)
          state_next = ST_RUN;
        else if (fault_det)
          unique case (resp)
            tofrp_pkg::RESP_IGNORE:   state_next = ST_RUN;
            tofrp_pkg::RESP_RUN_WAIT: state_next = ST_HOLD;
            tofrp_pkg::RESP_DISABLE:  state_next = retry_state;
            tofrp_pkg::RESP_LATCH:    state_next = ST_LATCH;
          endcase
      ST_RUN:   state_next = ST_RUN;
      // keep running for the delay, then retry or latch off per the retry code if still failing
      ST_HOLD:  if (delay_done) state_next = vout_ok_i ? ST_RUN : retry_state;
      ST_WAIT:  if (delay_done) state_next = ST_START;
      ST_LATCH: if (!flag_reg) state_next = ST_START;
    endcase
    // off command or another fault ends any sequence
    if (other_fault_i && state_reg != ST_OFF)
      state_next = ST_LATCH;
    if (!on_cmd_i)
      state_next = ST_OFF;
  end

  // fresh retry count after clear or off
  always_comb
  begin
    attempts_next = attempts_reg;
    if (state_reg == ST_WAIT && state_next == ST_START &&
        retry != tofrp_pkg::RETRY_FOREVER)
      attempts_next = attempts_reg + 3'd1;
    if (state_next == ST_OFF || (flag_reg && !flag_next))
      attempts_next = 3'd0;
  end

  wire out_en_next = (state_next == ST_START) || (state_next == ST_RUN) ||
                     (state_next == ST_HOLD);

  wire [15:0] rd_data_next =
    (cmd_i.code == tofrp_pkg::CMD_TON_LIMIT)  ? limit_reg :
    (cmd_i.code == tofrp_pkg::CMD_TON_POLICY) ? {8'h00, policy_reg} :
    (cmd_i.code == tofrp_pkg::CMD_TIME_UNIT)  ? {8'h00, unit_reg} :
    16'h0000;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      policy_reg <= tofrp_pkg::POLICY_RST;
      limit_reg  <= tofrp_pkg::LIMIT_RST;
      unit_reg   <= tofrp_pkg::TIME_UNIT_RST;
    end
    else
    begin
      if (wr_policy) policy_reg <= cmd_i.data[7:0];
      if (wr_limit)  limit_reg  <= cmd_i.data;
      if (wr_unit)   unit_reg   <= cmd_i.data[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg    <= ST_OFF;
      attempts_reg <= 3'd0;
      flag_reg     <= 1'b0;
      on_d_reg     <= 1'b0;
      out_en_reg   <= 1'b0;
      rd_data_reg  <= 16'h0000;
    end
    else
    begin
      state_reg    <= state_next;
      attempts_reg <= attempts_next;
      flag_reg     <= flag_next;
      on_d_reg     <= on_cmd_i;
      out_en_reg   <= out_en_next;
      if (cmd_i.rd) rd_data_reg <= rd_data_next;
    end
  end

  // elapsed ms in the current state; saturates so a long state never wraps
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ms_cnt_reg <= 16'h0000;
    else if (restart_tick)
      ms_cnt_reg <= 16'h0000;
    else if (ms_tick && ms_cnt_reg != 16'hFFFF)
      ms_cnt_reg <= ms_cnt_reg + 16'd1;
  end

  assign out_en_o   = out_en_reg;
  assign fault_o    = flag_reg;
  assign attempts_o = attempts_reg;
  assign rd_data_o  = rd_data_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_disable_fault;
    fault_det && on_cmd_i && !other_fault_i && resp == tofrp_pkg::RESP_DISABLE;
  endsequence

  a_noretry_latch: assert property (
    s_disable_fault ##0 (retry == tofrp_pkg::RETRY_NONE)
    |=> state_reg == ST_LATCH ##0 !out_en_o)
    else $error("no-retry fault did not latch off");

  a_retry_bound: assert property (
    (state_reg == ST_WAIT && retry != tofrp_pkg::RETRY_FOREVER)
    |-> attempts_reg < retry)
    else $error("restart attempts exceed retry code");

  a_wait_spacing: assert property (
    ($past(state_reg) == ST_WAIT && state_reg == ST_START && on_cmd_i
     && $past(on_cmd_i) && !$past(other_fault_i))
    |-> $past(ms_cnt_reg) >= $past(delay_ms))
    else $error("restart before delay expired");

  a_forever_retry: assert property (
    s_disable_fault ##0 (retry == tofrp_pkg::RETRY_FOREVER)
    |=> state_reg == ST_WAIT ##1 !out_en_o)
    else $error("continuous retry did not wait");

  a_hold_length: assert property (
    (state_reg == ST_HOLD && ms_cnt_reg < delay_ms && on_cmd_i
     && !other_fault_i) |=> state_reg == ST_HOLD)
    else $error("hold left before delay count");

  a_hold_output: assert property (
    (state_reg == ST_HOLD) |-> out_en_o)
    else $error("output off while running after fault");

  a_ignore_fault: assert property (
    (fault_det && resp == tofrp_pkg::RESP_IGNORE && on_cmd_i
     && !other_fault_i) |=> state_reg == ST_RUN && out_en_o)
    else $error("ignored fault changed operation");

  a_flag_clear: assert property (
    (flag_reg && flag_clr && !fault_det) |=> !fault_o)
    else $error("fault flag not cleared");

  a_timeout_off: assert property (
    (state_reg == ST_START && limit_reg == 16'h0000 && !vout_ok_i
     && on_cmd_i && !other_fault_i) |=> state_reg == ST_START)
    else $error("timeout raised with zero limit");

  a_attempt_reset: assert property (
    (!on_cmd_i) |=> attempts_o == 3'd0 ##0 state_reg == ST_OFF)
    else $error("attempt count not reset on off");

endmodule // tofrp_policy
`default_nettype wire

// ---- tb/tofrp_stage.sv ----
`timescale 1ns/10ps
`default_nettype none
module tofrp_stage (
  // clock and control
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic healthy_i,
  // output status
  output logic      vout_ok_o
);
  logic [3:0] ramp_reg = 4'h0;
  // a weak stage never ramps, so a start with a nonzero limit always times out
  always @(posedge clk_i)
  begin
    if (!en_i || !healthy_i)
      ramp_reg <= 4'h0;
    else if (ramp_reg != 4'hF)
      ramp_reg <= ramp_reg + 4'h1;
  end
  assign vout_ok_o = (ramp_reg > 4'h4);
endmodule // tofrp_stage
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int MS = 10;
  logic                  clk_i = 1'b0;
  logic                  rst_b_i = 1'b0;
  tofrp_pkg::tofrp_cmd_t cmd_i = '0;
  logic                  on_cmd_i = 1'b0;
  logic                  other_fault_i = 1'b0;
  logic                  fault_bit_clr_i = 1'b0;
  logic                  healthy = 1'b0;
  logic [15:0]           rd_data_o;
  logic                  vout_ok_i;
  logic                  out_en_o;
  logic                  fault_o;
  logic [2:0]            attempts_o;
  int                    mismatches = 0;
  int                    total_checks = 0;
  int                    cycles = 0;
  int                    n;

  always #4 clk_i = ~clk_i;

  tofrp_policy #(.MS_CYC(MS)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .cmd_i(cmd_i), .rd_data_o(rd_data_o), .on_cmd_i(on_cmd_i),
    .vout_ok_i(vout_ok_i), .other_fault_i(other_fault_i),
    .fault_bit_clr_i(fault_bit_clr_i), .out_en_o(out_en_o),
    .fault_o(fault_o), .attempts_o(attempts_o));
  tofrp_stage stage (.clk_i(clk_i), .en_i(out_en_o),
    .healthy_i(healthy), .vout_ok_o(vout_ok_i));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rng(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi)
    begin
      mismatches++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, v, lo, hi);
    end
  endtask

  // an idle cycle after each command keeps back-to-back strobes apart
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    cmd_i = '{1'b1, 1'b0, c, d};
    @(negedge clk_i);
    cmd_i = '0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    cmd_i = '{1'b0, 1'b1, c, 16'h0000};
    @(negedge clk_i);
    cmd_i = '0;
    cmp(rd_data_o, e);
    @(negedge clk_i);
  endtask

  // cycles until out_en_o reaches v, capped at mx
  task automatic wait_en(input logic v, input int mx);
    n = 0;
    while (out_en_o !== v && n < mx)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task automatic s_regs();
    rd(8'h63, 16'h00C0);
    rd(8'h62, 16'h0032);
    rd(8'hD2, 16'h0000);
    wr(8'h55, 16'h1234);
    rd(8'h55, 16'h0000);
    wr(8'h63, 16'h00A2);
    rd(8'h63, 16'h00A2);
  endtask

  // start that either ramps or has no limit: no fault, stays on
  task automatic s_good(input logic h, input logic [15:0] lim);
    wr(8'h62, lim);
    wr(8'h63, 16'h0088);
    healthy = h;
    on_cmd_i = 1'b1;
    wait_en(1'b1, 10);
    wait_en(1'b0, 100);
    cmp_rng(n, 100, 100);
    cmp(16'(fault_o), 16'h0000);
    on_cmd_i = 1'b0;
    healthy = 1'b0;
    wait_en(1'b0, 5);
  endtask

  task automatic s_resp(input logic [1:0] r, input int lo, input int hi);
    wr(8'h63, {8'h00, r, 6'b000010});
    on_cmd_i = 1'b1;
    wait_en(1'b1, 10);
    wait_en(1'b0, 300);
    cmp_rng(n, lo, hi);
    cmp(16'(fault_o), 16'(r != 2'b00));
    on_cmd_i = 1'b0;
    repeat (2) @(negedge clk_i);
    cmp(16'(fault_o), 16'h0000);
  endtask

  task automatic s_retry(input logic [2:0] c, input logic [2:0] d,
                         input logic [7:0] u, input int how);
    int exp;
    exp = (1 << d) * (u + 1) * MS;
    wr(8'hD2, {8'h00, u});
    wr(8'h63, {8'h00, 2'b10, c, d});
    on_cmd_i = 1'b1;
    wait_en(1'b1, 10);
    for (int i = 1; i <= c; i++)
    begin
      wait_en(1'b0, 40);
      wait_en(1'b1, 2000);
      cmp_rng(n, exp - 2, exp + 4);
      cmp(16'(attempts_o), 16'(i));
    end
    wait_en(1'b0, 40);
    wait_en(1'b1, exp + 50);
    cmp_rng(n, exp + 50, exp + 50);
    cmp(16'(fault_o), 16'h0001);
    if (how == 0)
      wr(8'h03, 16'h0000);
    fault_bit_clr_i = (how == 1);
    on_cmd_i = (how != 2);
    @(negedge clk_i);
    fault_bit_clr_i = 1'b0;
    on_cmd_i = 1'b1;
    repeat (2) @(negedge clk_i);
    cmp(16'(fault_o), 16'h0000);
    cmp(16'(attempts_o), 16'h0000);
    on_cmd_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic s_forever();
    wr(8'hD2, 16'h0000);
    wr(8'h63, 16'h00B8);
    on_cmd_i = 1'b1;
    repeat (8)
    begin
      wait_en(1'b1, 40);
      wait_en(1'b0, 40);
    end
    wait_en(1'b1, 40);
    cmp_rng(n, 8, 14);
    other_fault_i = 1'b1;
    repeat (2) @(negedge clk_i);
    cmp(16'(out_en_o), 16'h0000);
    other_fault_i = 1'b0;
    on_cmd_i = 1'b0;
    repeat (2) @(negedge clk_i);
    cmp(16'(attempts_o), 16'h0000);
  endtask

  initial
  begin
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    s_regs();
    s_good(1'b1, 16'h0002);
    s_good(1'b0, 16'h0000);
    wr(8'h62, 16'h0002);
    s_resp(2'b00, 300, 300);
    s_resp(2'b01, 56, 68);
    s_resp(2'b11, 18, 26);
    s_retry(3'd0, 3'd0, 8'h00, 0);
    s_retry(3'd1, 3'd1, 8'h01, 1);
    s_retry(3'd6, 3'd0, 8'h00, 2);
    s_retry(3'd2, 3'd7, 8'h00, 0);
    s_forever();
    end_of_test();
  end

  // watchdog sized well above the longest sequence
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
    end
  end
endmodule // testbench
`default_nettype wire
